// ---- rtl/sur_consts.vh ----
// Constants for the serial-number reader: opcodes, register map, fields, timing.
// Included by the design files; holds definitions only.
`ifndef SUR_CONSTS_VH
`define SUR_CONSTS_VH

// Serial protocol
`define SUR_READ_SERIAL_NUMBER_CMD 8'h83
`define SUR_FRAME_HDR_BITS         5'd24
`define SUR_ADDR_SEL_BIT           9
`define SUR_ERASED_BYTE            8'hff
`define SUR_SN_BYTES               16

// Register indices (Avalon word addresses)
`define SUR_REG_CTRL               2'h0
`define SUR_REG_STATUS             2'h1
`define SUR_REG_NVSTAT             2'h2
`define SUR_REG_COUNT              2'h3

// Field positions
`define SUR_CTRL_WEL_BIT           0
`define SUR_CTRL_ARM_BIT           1
`define SUR_ST_BUSY_BIT            0
`define SUR_ST_WEL_BIT             1
`define SUR_ST_ACTIVE_BIT          2
`define SUR_ST_ARMED_BIT           3
`define SUR_ST_PEND_BIT            4
`define SUR_NV_BPL_BIT             2
`define SUR_NV_BPH_BIT             3
`define SUR_NV_SWD_BIT             7

// Reset and delivery values
`define SUR_WEL_RESET              1'b0
`define SUR_BUSY_RESET             1'b0
`define SUR_NV_DELIVERY            1'b0

// Self-timed write cycle: time in microseconds, clock in MHz
`define SUR_TW_US                  5000
`define SUR_CLK_MHZ                100
`define SUR_TW_CYCLES              20'd500000

`endif

// ---- rtl/sur_sync3.v ----
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes inputs arrive from outside core_clk; output moves when stages 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none

module sur_sync3 #(
  parameter       WIDTH     = 1,
  parameter [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Asynchronous input and filtered output
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      // One driver per lane bit
      assign sync_out[i] = out_reg;
      // Stage chain; first stage feeds only the second
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_reg      <= RESET_VAL[i];
          s2_reg      <= RESET_VAL[i];
          s3_reg      <= RESET_VAL[i];
          out_reg     <= RESET_VAL[i];
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg; // Accept once two stages agree
          end
        end
      end
    end
  endgenerate

endmodule // sur_sync3

`default_nettype wire

// ---- rtl/sur_uid_rom.v ----
// Sixteen-byte read-only serial-number store with registered read data.
// Assumes the address is held one cycle before the data is used.
`timescale 1ns/10ps
`default_nettype none

module sur_uid_rom #(
  // Arbitrary content, no meaning beyond uniqueness in simulation
  parameter [127:0] UID_VALUE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
) (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Read port
  input  wire [3:0] rd_addr,
  output reg  [7:0] rd_data_reg
);

  // No write port exists: content can never change
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= UID_VALUE[{rd_addr, 3'b000} +: 8];
    end
  end

endmodule // sur_uid_rom

`default_nettype wire

// ---- rtl/sur_uid_reader.v ----
// Serial-number reader slice of an SPI EEPROM with power-up state and status bits.
// Assumes SPI pins are asynchronous to core_clk and sclk is well below core_clk/8.
`timescale 1ns/10ps
`default_nettype none
`include "sur_consts.vh"

module sur_uid_reader #(
  parameter [19:0] TW_CYCLES = `SUR_TW_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // Delivery-state initialisation of non-volatile bits
  input  wire        factory_init,
  // SPI pins
  input  wire        spi_sel_n,
  input  wire        spi_sclk,
  input  wire        spi_din,
  output reg         spi_dout,
  output reg         spi_dout_oe,
  // Avalon-MM slave
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest
);

  // Frame states:
  //   idle   - waiting for a select falling edge; nothing is driven
  //   header - collecting the opcode and the 16 address bits
  //   send   - streaming serial-number bytes on each link clock fall
  //   ignore - frame refused; stays silent until select rises
  // A refused frame is never retried inside the same select period,
  // so a host that reads during a write cycle sees a floating line
  // and has to deselect and try again once busy has cleared.
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_HEADER = 2'd1;
  localparam [1:0] ST_SEND   = 2'd2;
  localparam [1:0] ST_IGNORE = 2'd3;

  // Synchronised pins and edge history
  wire [2:0] pins_sync;
  wire       sel_n_s;
  wire       sclk_s;
  wire       din_s;
  reg        sel_n_d_reg;
  reg        sclk_d_reg;
  wire       sel_fall;
  wire       sel_rise;
  wire       sclk_rise;
  wire       sclk_fall;

  // Frame state
  reg [1:0]  state_reg;
  reg [4:0]  hdr_cnt_reg;
  reg [22:0] hdr_shift_reg;
  reg [3:0]  index_reg;
  reg [2:0]  bit_pos_reg;
  reg [7:0]  out_shift_reg;
  reg        id_page_reg;
  reg        armed_reg;
  reg [15:0] byte_count_reg;
  wire [23:0] hdr_full;
  wire [7:0] rom_data;
  wire [7:0] next_byte;

  // Status and write-cycle state
  reg        write_enable_latch_reg;
  reg        write_arm_reg;
  reg        write_busy_flag_reg;
  reg [19:0] tw_cnt_reg;
  reg        status_write_disable_reg;
  reg        block_protect_high_reg;
  reg        block_protect_low_reg;

  // Bus handshake
  wire       bus_req;
  wire       bus_wr_take;

  // All three pins run through the same filter so that their relative
  // timing is kept: data is sampled on the filtered clock rise, and
  // both see the same four-cycle delay. The link clock must stay high
  // and low for at least two core cycles each, or edges are lost.
  // Deselected level is high, clock and data idle low
  sur_sync3 #(
    .WIDTH     (3),
    .RESET_VAL (8'h04)
  ) u_sync (
    .clk      (core_clk),
    .resetn   (resetn),
    .async_in ({spi_sel_n, spi_sclk, spi_din}),
    .sync_out (pins_sync)
  );

  assign sel_n_s = pins_sync[2];
  assign sclk_s  = pins_sync[1];
  assign din_s   = pins_sync[0];

  // Serial-number store has no write path
  sur_uid_rom u_rom (
    .clk         (core_clk),
    .resetn      (resetn),
    .rd_addr     (index_reg),
    .rd_data_reg (rom_data)
  );

  // Edge detection on filtered pins. The history registers reset to the
  // idle levels of their pins, so no false edge appears while the pins sit idle;
  // a select held low across reset still shows a falling edge and opens a frame.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_n_d_reg <= 1'b1;
      sclk_d_reg  <= 1'b0;
    end else begin
      sel_n_d_reg <= sel_n_s;
      sclk_d_reg  <= sclk_s;
    end
  end

  assign sel_fall  = sel_n_d_reg & ~sel_n_s;
  assign sel_rise  = ~sel_n_d_reg & sel_n_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s;
  assign hdr_full  = {hdr_shift_reg, din_s};

  // Identification-page reads return the delivered erased value
  assign next_byte = id_page_reg ? `SUR_ERASED_BYTE : rom_data;

  // Frame sequencer: header capture, byte streaming, deselect.
  // The header is 24 bits, opcode first and address last, taken on the
  // filtered clock rise. Output bits change on the filtered clock fall,
  // so the host sees each bit stand for a whole link clock period.
  // The store's read data is registered, so the index is loaded at the
  // end of the header and the first byte is ready long before the first
  // falling edge; the next index is loaded on the last bit of a byte,
  // a full bit time before that byte's data is needed.
  // Deselect wins over everything else at any point of the frame.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= ST_IDLE;
      hdr_cnt_reg    <= 5'd0;
      hdr_shift_reg  <= 23'd0;
      index_reg      <= 4'h0;
      bit_pos_reg    <= 3'd0;
      out_shift_reg  <= 8'h00;
      id_page_reg    <= 1'b0;
      armed_reg      <= 1'b0;
      byte_count_reg <= 16'd0;
      spi_dout       <= 1'b0;
      spi_dout_oe    <= 1'b0;
    end else if (sel_n_s) begin
      // Deselect at any point ends the frame and floats the output
      state_reg   <= ST_IDLE;
      spi_dout_oe <= 1'b0;
      spi_dout    <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Only a seen falling edge opens a frame
          if (sel_fall) begin
            state_reg   <= ST_HEADER;
            armed_reg   <= 1'b1;
            hdr_cnt_reg <= 5'd0;
          end
        end
        ST_HEADER: begin
          if (sclk_rise) begin
            hdr_shift_reg <= hdr_full[22:0];
            hdr_cnt_reg   <= hdr_cnt_reg + 5'd1;
            if (hdr_cnt_reg == `SUR_FRAME_HDR_BITS - 5'd1) begin
              if (hdr_full[23:16] != `SUR_READ_SERIAL_NUMBER_CMD) begin
                state_reg <= ST_IGNORE;
              end else if (write_busy_flag_reg) begin
                state_reg <= ST_IGNORE;
              end else begin
                state_reg      <= ST_SEND;
                index_reg      <= hdr_full[3:0];
                id_page_reg    <= ~hdr_full[`SUR_ADDR_SEL_BIT];
                bit_pos_reg    <= 3'd0;
                byte_count_reg <= 16'd0;
              end
            end
          end
        end
        ST_SEND: begin
          // Shift on falling clock edge, most significant bit first
          if (sclk_fall) begin
            spi_dout_oe <= 1'b1;
            bit_pos_reg <= bit_pos_reg + 3'd1;
            if (bit_pos_reg == 3'd0) begin
              spi_dout      <= next_byte[7];
              out_shift_reg <= {next_byte[6:0], 1'b0};
            end else begin
              spi_dout      <= out_shift_reg[7];
              out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            end
            if (bit_pos_reg == 3'd7) begin
              index_reg      <= index_reg + 4'h1;
              byte_count_reg <= byte_count_reg + 16'd1;
            end
          end
        end
        ST_IGNORE: begin
          spi_dout_oe <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Self-timed write cycle timer started at select rise when armed.
  // Busy covers exactly the programmed number of core cycles; while it
  // is set, serial reads are refused and protection bits are locked.
  // A select rise that falls on the last busy cycle starts no new cycle;
  // the arm bit then stays set and the next select rise starts it.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      write_busy_flag_reg <= `SUR_BUSY_RESET;
      tw_cnt_reg          <= 20'd0;
    end else if (write_busy_flag_reg) begin
      if (tw_cnt_reg == TW_CYCLES - 20'd1) begin
        write_busy_flag_reg <= 1'b0;
        tw_cnt_reg          <= 20'd0;
      end else begin
        tw_cnt_reg <= tw_cnt_reg + 20'd1;
      end
    end else if (sel_rise && write_arm_reg) begin
      write_busy_flag_reg <= 1'b1;
      tw_cnt_reg          <= 20'd0;
    end
  end

  // Avalon request is taken in the cycle waitrequest is low
  assign bus_req     = avs_read | avs_write;
  assign bus_wr_take = avs_write & ~avs_waitrequest;

  // Waitrequest drops for one cycle, then rises again.
  // Every access takes two cycles: request seen with waitrequest high,
  // then taken in the cycle waitrequest is low. A master that keeps its
  // request up after the low cycle gets a second transfer two cycles later.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data captured while waitrequest is high, stands during the low cycle
  // and keeps its value until the next read, so a slow master is safe.
  // Status bits are a snapshot taken one cycle before the transfer.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `SUR_REG_CTRL: begin
          avs_readdata <= {30'd0, write_arm_reg, write_enable_latch_reg};
        end
        `SUR_REG_STATUS: begin
          avs_readdata <= {27'd0, write_arm_reg, armed_reg, (state_reg == ST_SEND),
                           write_enable_latch_reg, write_busy_flag_reg};
        end
        `SUR_REG_NVSTAT: begin
          avs_readdata <= {24'd0, status_write_disable_reg, 3'b000, block_protect_high_reg,
                           block_protect_low_reg, write_enable_latch_reg, write_busy_flag_reg};
        end
        `SUR_REG_COUNT: begin
          avs_readdata <= {16'd0, byte_count_reg};
        end
        default: begin
          avs_readdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Control bits: latch and arm; hardware consumes arm when a cycle starts.
  // A software write in the same cycle wins over the hardware clear, so
  // a freshly written arm bit is never lost.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      write_enable_latch_reg <= `SUR_WEL_RESET;
      write_arm_reg          <= 1'b0;
    end else if (bus_wr_take && avs_address == `SUR_REG_CTRL) begin
      write_enable_latch_reg <= avs_writedata[`SUR_CTRL_WEL_BIT];
      write_arm_reg          <= avs_writedata[`SUR_CTRL_ARM_BIT];
    end else if (sel_rise && write_arm_reg && !write_busy_flag_reg) begin
      write_arm_reg          <= 1'b0;
      write_enable_latch_reg <= 1'b0;
    end
  end

  // Non-volatile bits: untouched by reset, zeroed by delivery init, loaded by enabled bus writes.
  // They model cells that survive power loss, so they carry no reset
  // branch and stay unknown until delivery init or an enabled bus write sets them.
  // Writes need the enable latch and no running write cycle.
  always @(posedge core_clk) begin
    if (factory_init) begin
      status_write_disable_reg <= `SUR_NV_DELIVERY;
      block_protect_high_reg   <= `SUR_NV_DELIVERY;
      block_protect_low_reg    <= `SUR_NV_DELIVERY;
    end else if (bus_wr_take && avs_address == `SUR_REG_NVSTAT &&
                 write_enable_latch_reg && !write_busy_flag_reg) begin
      status_write_disable_reg <= avs_writedata[`SUR_NV_SWD_BIT];
      block_protect_high_reg   <= avs_writedata[`SUR_NV_BPH_BIT];
      block_protect_low_reg    <= avs_writedata[`SUR_NV_BPL_BIT];
    end
  end

endmodule // sur_uid_reader

`default_nettype wire

// ---- test/sur_spi_host.sv ----
// SPI host model for the serial-number reader, mode 0, link clock of 8 core_clk cycles.
// Assumes the bench core_clk; the link clock stands low between frames.
`timescale 1ns/10ps
`default_nettype none

module sur_spi_host (
  // Bench clock
  input  wire logic core_clk,
  // SPI pins
  output logic      spi_sel_n,
  output logic      spi_sclk,
  output logic      spi_din,
  input  wire logic spi_dout,
  input  wire logic spi_dout_oe
);
  logic         alt = 1'b0;
  int           up = 0;
  logic [127:0] got;
  logic         seen_oe;
  wire          q = spi_dout_oe ? spi_dout : alt; // Undriven line shows a changing level

  // Idle pin levels
  initial begin
    spi_sel_n = 1'b1;
    spi_sclk = 1'b0;
    spi_din = 1'b0;
  end

  // Toggling stand-in for a released data line, and time since power-up
  always @(posedge core_clk) begin
    alt <= ~alt;
    up <= up + 1;
  end

  // One frame: 24 header bits, then nbits read bits sampled before each fall
  task automatic xfer(input logic [23:0] hdr, input int nbits);
    seen_oe = 1'b0;
    got = '0;
    while (up < 10000) @(posedge core_clk);
    @(posedge core_clk);
    spi_sel_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 24 + nbits; i++) begin
      spi_sclk <= 1'b0;
      spi_din <= (i < 24) ? hdr[23 - i] : ~spi_din;
      repeat (4) @(posedge core_clk);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      if (i >= 24) begin
        got = {got[126:0], q};
        seen_oe = seen_oe | spi_dout_oe;
      end
    end
    spi_sel_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    spi_sclk <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // sur_spi_host
`default_nettype wire

// ---- test/sur_uid_reader_properties.sv ----
// Port checker for the serial-number reader.
// Assumes it is bound into sur_uid_reader and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module sur_uid_props #(
  parameter [19:0] TW_CYCLES = 20'd50
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // SPI pins
  input wire logic        spi_sel_n,
  input wire logic        spi_sclk,
  input wire logic        spi_dout_oe,
  // Avalon-MM
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  reg       sclk_d;
  reg [5:0] rise_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Counts link clock rises since select went low
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
      rise_cnt <= 6'h00;
    end else begin
      sclk_d <= spi_sclk;
      if (spi_sel_n)
        rise_cnt <= 6'h00;
      else if (spi_sclk && !sclk_d && rise_cnt != 6'h3f)
        rise_cnt <= rise_cnt + 6'h01;
    end
  end

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  chk_reset_state: assert property ($rose(resetn) |-> !spi_dout_oe && avs_waitrequest && avs_readdata == 32'h0)
    else $error("state after reset wrong");
  chk_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus answer not one cycle");
  chk_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low without request");
  chk_readdata_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
    else $error("read data moved without read");
  chk_oe_desel: assert property (spi_sel_n [*8] |-> !spi_dout_oe)
    else $error("output driven while deselected");
  chk_oe_select: assert property ($rose(spi_dout_oe) |-> !spi_sel_n)
    else $error("output enabled without select");
  chk_oe_after_hdr: assert property ($rose(spi_dout_oe) |-> rise_cnt >= 6'd24 && rise_cnt <= 6'd25)
    else $error("output started off the header end");
  chk_oe_fall_sel: assert property ($fell(spi_dout_oe) |-> spi_sel_n)
    else $error("output dropped with select low");
endmodule // sur_uid_props

bind sur_uid_reader sur_uid_props #(.TW_CYCLES(TW_CYCLES)) i_props (
  .core_clk(core_clk), .resetn(resetn), .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk),
  .spi_dout_oe(spi_dout_oe), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

// ---- test/sur_uid_reader_bench.sv ----
// Self-checking bench for the serial-number reader.
// Assumes design files, the SPI host model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "sur_consts.vh"
`define SUR_CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module sur_uid_reader_bench;
  logic         core_clk;
  logic         resetn;
  logic         factory_init;
  logic [1:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  wire  [31:0]  avs_readdata;
  wire          avs_waitrequest;
  wire          spi_sel_n, spi_sclk, spi_din, spi_dout, spi_dout_oe;
  int           n_errors = 0;
  int           compares = 0;
  int           cyc = 0;
  logic [31:0]  rd;
  logic [127:0] first;
  localparam logic [7:0] CMD = `SUR_READ_SERIAL_NUMBER_CMD;

  sur_uid_reader #(.TW_CYCLES(20'd1000)) i_sur_uid_reader (
    .core_clk(core_clk), .resetn(resetn), .factory_init(factory_init),
    .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk), .spi_din(spi_din),
    .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );
  sur_spi_host host (
    .core_clk(core_clk), .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk),
    .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe)
  );

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end

  task automatic close_out;
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bus cycles hold the request until waitrequest is sampled low
  task automatic bus_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [1:0] a);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic pulse_reset;
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
  endtask
  task automatic deliver;
    factory_init <= 1'b1;
    repeat (2) @(posedge core_clk);
    factory_init <= 1'b0;
  endtask

  // Power-up state, delivery state and kept protection bits
  task automatic t_power_up;
    bus_rd(`SUR_REG_STATUS);
    `SUR_CHK("status", 32'h0, rd & 32'h1f)
    deliver;
    bus_rd(`SUR_REG_NVSTAT);
    `SUR_CHK("nv delivered", 32'h0, rd & 32'h8c)
    bus_wr(`SUR_REG_CTRL, 32'h1);
    bus_wr(`SUR_REG_NVSTAT, 32'h8c);
    pulse_reset;
    bus_rd(`SUR_REG_STATUS);
    `SUR_CHK("wel busy", 32'h0, rd & 32'h3)
    bus_rd(`SUR_REG_NVSTAT);
    `SUR_CHK("nv kept", 32'h8c, rd & 32'h8c)
    deliver;
    bus_rd(`SUR_REG_NVSTAT);
    `SUR_CHK("nv again", 32'h0, rd & 32'h8c)
  endtask

  // Streamed read across the wrap, then single bytes against it
  task automatic t_uid_stream;
    host.xfer({CMD, 16'h020e}, 24);
    first = host.got;
    `SUR_CHK("oe", 1'b1, host.seen_oe)
    bus_rd(`SUR_REG_COUNT);
    `SUR_CHK("byte count", 32'h3, rd)
    host.xfer({CMD, 16'h020f}, 8);
    `SUR_CHK("next byte", first[15:8], host.got[7:0])
    host.xfer({CMD, 16'hfe0e}, 8);
    `SUR_CHK("same byte", first[23:16], host.got[7:0])
    host.xfer({CMD, 16'h0200}, 8);
    `SUR_CHK("wrapped", first[7:0], host.got[7:0])
  endtask

  // Id page bytes, other opcode and a mid-byte abort
  task automatic t_refused;
    host.xfer({CMD, 16'h0005}, 16);
    `SUR_CHK("blank", 16'hffff, host.got[15:0])
    host.xfer({8'h03, 16'h0205}, 8);
    `SUR_CHK("other opcode", 1'b0, host.seen_oe)
    host.xfer({CMD, 16'h0205}, 12);
    repeat (8) @(posedge core_clk);
    `SUR_CHK("oe after abort", 1'b0, spi_dout_oe)
  endtask

  // Write cycle started by select rise blocks the read until it ends
  task automatic t_busy;
    bus_wr(`SUR_REG_CTRL, 32'h2);
    host.xfer(24'h0, 0);
    bus_rd(`SUR_REG_STATUS);
    `SUR_CHK("busy set", 32'h1, rd & 32'h11)
    host.xfer({CMD, 16'h0200}, 8);
    `SUR_CHK("read busy", 1'b0, host.seen_oe)
    repeat (400) @(posedge core_clk);
    bus_rd(`SUR_REG_STATUS);
    `SUR_CHK("busy held", 32'h1, rd & 32'h1)
    repeat (400) @(posedge core_clk);
    bus_rd(`SUR_REG_STATUS);
    `SUR_CHK("busy done", 32'h0, rd & 32'h1)
    host.xfer({CMD, 16'h0200}, 8);
    `SUR_CHK("read after", first[7:0], host.got[7:0])
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    factory_init = 1'b0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    @(posedge core_clk);
    pulse_reset;
    t_power_up;
    t_uid_stream;
    t_refused;
    t_busy;
    close_out;
  end
endmodule // sur_uid_reader_bench
`default_nettype wire
